// *** pkg/sem_host_pkg.sv ***
// Constants for the token-space host controller.
// Assumes one 10 MHz system clock; the memory pins are driven from flip-flops.
package sem_host_pkg;
	localparam int unsigned CLK_PERIOD_NS   = 100;
	localparam int unsigned DATA_WIDTH      = 36;
	localparam int unsigned ADDR_WIDTH      = 16;
	localparam int unsigned FLAG_COUNT      = 8;
	localparam int unsigned FLAG_BITS       = 3;
	// Strobe width and gap between strobes, in ns
	localparam int unsigned STROBE_NS       = 200;
	localparam int unsigned GAP_NS          = 100;
	localparam int unsigned STROBE_CYCLES   = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned GAP_CYCLES      = (GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0]  TIMER_RESET     = 4'h0;
	localparam logic [3:0]  BYTE_LANES_ON   = 4'h0;
	localparam logic [3:0]  BYTE_LANES_OFF  = 4'hf;

	typedef enum logic [1:0]
	{
		CMD_ACQUIRE,
		CMD_RELEASE,
		CMD_INIT,
		CMD_PEEK
	} cmd_t;
endpackage

// *** pkg/sem_strobe_if.sv ***
// Carries one semaphore access between the sequencer and the pin driver.
// Assumes both ends share clk_sys.
`timescale 1ns/1ps
interface sem_strobe_if;
	import sem_host_pkg::*;
	logic                  start;
	logic                  write;
	logic [FLAG_BITS-1:0]  index;
	logic                  wbit;
	logic                  done;
	logic                  rbit;

	modport seq
	(
		output start,
		output write,
		output index,
		output wbit,
		input  done,
		input  rbit
	);
	modport drv
	(
		input  start,
		input  write,
		input  index,
		input  wbit,
		output done,
		output rbit
	);
endinterface

// *** tb/sem_flag_model.sv ***
// Model of the far device's eight token flags; host on the left port.
// Assumes host pins leave flip-flops; the right port is worked by task calls.
`timescale 1ns/1ps
module sem_flag_model
	import sem_host_pkg::*;
(
	// Host pins
	input  wire logic                  token_space_select_n,
	input  wire logic                  array_select_n,
	input  wire logic                  write_n,
	input  wire logic                  output_enable_n,
	input  wire logic [3:0]            byte_lane_enable_n,
	input  wire logic [ADDR_WIDTH-1:0] address,
	input  wire logic [DATA_WIDTH-1:0] data_out,
	// Read bus
	output logic      [DATA_WIDTH-1:0] data_in
);
	// Not self-initialising: left requests start stuck low
	logic [7:0] req_l = 8'hff;
	logic [7:0] req_r = 8'h00;
	logic [7:0] own_l = 8'hff;
	logic [7:0] own_r = 8'h00;
	logic       held = 1'b1;

	// Release hands a flag to a pending side; writes apply one at a time
	task automatic settle(input int i);
	begin
		if (own_l[i] && !req_l[i])
			own_l[i] = 1'b0;
		if (own_r[i] && !req_r[i])
			own_r[i] = 1'b0;
		if (!own_l[i] && !own_r[i])
		begin
			own_l[i] = req_l[i];
			own_r[i] = req_r[i] && !req_l[i];
		end
	end
	endtask

	task automatic other_write(input logic [2:0] i, input logic b);
	begin
		req_r[i] = !b;
		settle(i);
	end
	endtask

	always @(negedge write_n)
	begin
		#1;
		if (!token_space_select_n && array_select_n)
		begin
			req_l[address[2:0]] = !data_out[0];
			settle(address[2:0]);
		end
	end

	// Latched at read start so a far write cannot change it mid-read
	always @(negedge output_enable_n)
	begin
		#1;
		held = !own_l[address[2:0]];
	end

	// Undriven lanes show the inverse of the flag
	always_comb
		for (int b = 0; b < DATA_WIDTH; b++)
			data_in[b] = (!token_space_select_n && !output_enable_n
				&& !byte_lane_enable_n[b/9]) ? held : !held;
endmodule

// *** tb/sem_host_checker.sv ***
// Assertions on the host controller's pins and command port.
// Assumes one clock domain; attached to the controller by bind.
`timescale 1ns/1ps
module sem_host_checker
	import sem_host_pkg::*;
#(
	parameter int unsigned RETRY_LIMIT = 16
)
(
	// Clock and command side
	input wire logic                  clk_sys,
	input wire logic                  reset_n,
	input wire logic                  clk_en,
	input wire logic                  cmd_valid,
	input wire logic                  cmd_ready,
	input wire sem_host_pkg::cmd_t    cmd_op,
	input wire logic                  rsp_valid,
	input wire logic                  rsp_granted,
	input wire logic                  rsp_flag,
	// Memory pins
	input wire logic                  token_space_select_n,
	input wire logic                  array_select_n,
	input wire logic                  write_n,
	input wire logic                  output_enable_n,
	input wire logic [3:0]            byte_lane_enable_n,
	input wire logic [ADDR_WIDTH-1:0] address,
	input wire logic [DATA_WIDTH-1:0] data_out,
	input wire logic                  data_oe_n
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);
	logic take;
	assign take = cmd_valid && cmd_ready && clk_en;

	property p_arr; !token_space_select_n |-> array_select_n; endproperty
	property p_addr; !token_space_select_n |-> address[ADDR_WIDTH-1:FLAG_BITS] == '0; endproperty
	property p_wbit; !write_n |-> !data_oe_n && data_out[DATA_WIDTH-1:1] == '0; endproperty
	property p_strb;
		(!write_n || !output_enable_n) |-> !token_space_select_n && byte_lane_enable_n == BYTE_LANES_ON;
	endproperty
	property p_oneway; !write_n |-> output_enable_n; endproperty
	property p_acq;
		take && cmd_op == CMD_ACQUIRE |-> output_enable_n throughout (##[1:4] (!write_n && !data_out[0]));
	endproperty
	property p_rel; take && cmd_op == CMD_RELEASE |-> ##[1:4] (!write_n && data_out[0]); endproperty
	property p_gap; $rose(output_enable_n) |-> token_space_select_n; endproperty
	property p_grant; rsp_valid && rsp_granted |-> !rsp_flag; endproperty
	// Pins leave flip-flops, so a frozen clock must hold every strobe
	property p_hold;
		!clk_en |=> $stable(token_space_select_n) && $stable(write_n)
			&& $stable(output_enable_n) && $stable(address);
	endproperty

	a_arr: assert property (p_arr)
		else $error("array select low in flag access");
	a_addr: assert property (p_addr)
		else $error("high address bits set");
	a_wbit: assert property (p_wbit)
		else $error("bad write data");
	a_strb: assert property (p_strb)
		else $error("strobe outside flag select");
	a_oneway: assert property (p_oneway)
		else $error("read and write together");
	a_acq: assert property (p_acq)
		else $error("acquire did not write zero first");
	a_rel: assert property (p_rel)
		else $error("release did not write one");
	a_gap: assert property (p_gap)
		else $error("select held across reads");
	a_grant: assert property (p_grant)
		else $error("grant with flag one");
	a_hold: assert property (p_hold)
		else $error("pins moved with clock enable low");
	c_acq: cover property (take && cmd_op == CMD_ACQUIRE);
	c_fail: cover property (rsp_valid && !rsp_granted);
	c_rel: cover property (take && cmd_op == CMD_RELEASE);
	c_freeze: cover property (!clk_en && !token_space_select_n);
endmodule

bind sem_host_ctrl sem_host_checker #(.RETRY_LIMIT(RETRY_LIMIT)) chk
(
	.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en), .cmd_valid(cmd_valid),
	.cmd_ready(cmd_ready), .cmd_op(cmd_op), .rsp_valid(rsp_valid),
	.rsp_granted(rsp_granted), .rsp_flag(rsp_flag),
	.token_space_select_n(token_space_select_n), .array_select_n(array_select_n),
	.write_n(write_n), .output_enable_n(output_enable_n),
	.byte_lane_enable_n(byte_lane_enable_n), .address(address),
	.data_out(data_out), .data_oe_n(data_oe_n)
);

// *** tb/sem_host_ctrl_bench.sv ***
// Self-checking bench for the token-flag host controller.
// Assumes the flag model on the pins; its right port is worked from here.
`timescale 1ns/1ps
module sem_host_ctrl_bench;
	import sem_host_pkg::*;
	// far: 0 idle, 1 right writes zero, 2 right writes one, before the command
	typedef struct { cmd_t op; logic [2:0] idx; int far; logic flag; } row_t;
	logic                  clk_sys, reset_n, clk_en, cmd_valid, cmd_ready;
	logic                  rsp_valid, rsp_granted, rsp_flag, sel_n, arr_n, wr_n, oe_n, doe_n;
	cmd_t                  cmd_op;
	logic [2:0]            cmd_index;
	logic [3:0]            be_n;
	logic [ADDR_WIDTH-1:0] addr;
	logic [DATA_WIDTH-1:0] dout, din;
	int                    n_mismatch = 0;
	int                    cmp_count = 0;
	row_t                  rows [10] = '{
		'{CMD_ACQUIRE, 3'h3, 0, 1'b0}, '{CMD_PEEK, 3'h3, 1, 1'b0},
		'{CMD_RELEASE, 3'h3, 0, 1'b1}, '{CMD_PEEK, 3'h3, 0, 1'b1},
		'{CMD_ACQUIRE, 3'h3, 0, 1'b1}, '{CMD_ACQUIRE, 3'h3, 2, 1'b0},
		'{CMD_ACQUIRE, 3'h7, 0, 1'b0}, '{CMD_PEEK, 3'h7, 2, 1'b0},
		'{CMD_RELEASE, 3'h3, 0, 1'b1}, '{CMD_RELEASE, 3'h7, 0, 1'b1}};

	sem_host_ctrl #(.RETRY_LIMIT(2)) uut
	(
		.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_index(cmd_index),
		.rsp_valid(rsp_valid), .rsp_granted(rsp_granted), .rsp_flag(rsp_flag),
		.token_space_select_n(sel_n), .array_select_n(arr_n), .write_n(wr_n),
		.output_enable_n(oe_n), .byte_lane_enable_n(be_n), .address(addr),
		.data_out(dout), .data_oe_n(doe_n), .data_in(din)
	);
	sem_flag_model part
	(
		.token_space_select_n(sel_n), .array_select_n(arr_n), .write_n(wr_n),
		.output_enable_n(oe_n), .byte_lane_enable_n(be_n), .address(addr),
		.data_out(dout), .data_in(din)
	);

	initial
	begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	task automatic cmp_bit(input logic got, input logic exp);
	begin
		cmp_count++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	end
	endtask

	task automatic run(input cmd_t op, input logic [2:0] idx);
		int n;
	begin
		@(posedge clk_sys);
		#1;
		cmd_valid = 1'b1;
		cmd_op = op;
		cmd_index = idx;
		@(posedge clk_sys);
		#1;
		cmd_valid = 1'b0;
		n = 0;
		while (rsp_valid !== 1'b1 && n < 300)
		begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		if (n == 300)
			n_mismatch++;
	end
	endtask

	task automatic test_done;
	begin
		$display("compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	end
	endtask

	initial
	begin
		#3000000;
		n_mismatch++;
		test_done();
	end

	initial
	begin
		reset_n = 1'b0;
		clk_en = 1'b1;
		cmd_valid = 1'b0;
		cmd_op = CMD_INIT;
		cmd_index = 3'h0;
		repeat (8) @(posedge clk_sys);
		#1;
		cmp_bit(sel_n, 1'b1);
		cmp_bit(arr_n, 1'b1);
		cmp_bit(cmd_ready, 1'b1);
		cmp_bit(rsp_valid, 1'b0);
		reset_n = 1'b1;
		for (int i = 0; i < 8; i++)
			part.other_write(i[2:0], 1'b1);
		run(CMD_INIT, 3'h0);
		cmp_bit(rsp_flag, 1'b1);
		$display("reset and init test done");
		foreach (rows[i])
		begin
			if (rows[i].far != 0)
				part.other_write(rows[i].idx, rows[i].far == 2);
			run(rows[i].op, rows[i].idx);
			cmp_bit(rsp_flag, rows[i].flag);
			cmp_bit(rsp_granted, !rows[i].flag);
			$display("row %0d test done", i);
		end
		// Clock enable dropped in mid-strobe must freeze the access
		fork
			run(CMD_ACQUIRE, 3'h4);
			begin
				repeat (3) @(posedge clk_sys);
				#1;
				cmp_bit(sel_n, 1'b0);
				clk_en = 1'b0;
				repeat (5) @(posedge clk_sys);
				#1;
				cmp_bit(sel_n, 1'b0);
				cmp_bit(wr_n, 1'b0);
				clk_en = 1'b1;
			end
		join
		cmp_bit(rsp_granted, 1'b1);
		cmp_bit(rsp_flag, 1'b0);
		$display("clock enable test done");
		// Far request lands during the host's write strobe
		fork
			run(CMD_ACQUIRE, 3'h1);
			begin
				repeat (3) @(posedge clk_sys);
				#1;
				part.other_write(3'h1, 1'b0);
			end
		join
		cmp_bit(rsp_granted ^ part.own_r[1], 1'b1);
		$display("contention test done");
		// Reset in mid-strobe drops select and abandons the command
		@(posedge clk_sys);
		#1;
		cmd_valid = 1'b1;
		cmd_op = CMD_ACQUIRE;
		cmd_index = 3'h2;
		@(posedge clk_sys);
		#1;
		cmd_valid = 1'b0;
		@(posedge clk_sys);
		#1;
		cmp_bit(sel_n, 1'b0);
		reset_n = 1'b0;
		@(posedge clk_sys);
		#1;
		cmp_bit(sel_n, 1'b1);
		cmp_bit(cmd_ready, 1'b1);
		reset_n = 1'b1;
		run(CMD_RELEASE, 3'h2);
		cmp_bit(rsp_flag, 1'b1);
		cmp_bit(part.own_l[2], 1'b0);
		$display("mid-run reset test done");
		test_done();
	end
endmodule

// *** verilog/sem_host_ctrl.sv ***
// Host controller for one port of a dual-port memory's token flags.
// Assumes the opposite port belongs to another agent and this clock is 10 MHz.
//
// How it works
// [RL1] Eight flags, separate from the memory array
// [RL2] Write zero requests, write one releases
// [RL3] Token select low, then ordinary access strobes
// [RL4] Flag chosen by three low address bits
// [RL5] Only data bit zero is written
// [RL6] Winning zero reads zero here, one there
// [RL7] Holder alone changes a taken flag
// [RL8] Holder's one frees the flag
// [RL9] Loser's zero stays pending until freed
// [RL10] Pending request takes ownership on release
// [RL11] Read value spread across all bits
// [RL12] Read latched until select or enable drop
// [RL13] Byte lanes only gate read outputs
// [RL14] Always write zero before reading back; CMD_PEEK reads without writing first
// [RL15] After failure, re-read with gaps or release
// [RL16] Simultaneous requests yield exactly one winner
// [RL17] Software frees every flag at start-up
// [RL18] Array select high during token access
// [RL19] Write bit zero, read all bits
// [RL20] Stray one from non-holder changes nothing
`timescale 1ns/1ps
module sem_host_ctrl
	import sem_host_pkg::*;
#(
	parameter int unsigned RETRY_LIMIT = 16
)
(
	// Clock and reset
	input  wire logic                    clk_sys,
	input  wire logic                    reset_n,
	input  wire logic                    clk_en,
	// Command port
	input  wire logic                    cmd_valid,
	output logic                         cmd_ready,
	input  wire sem_host_pkg::cmd_t      cmd_op,
	input  wire logic [FLAG_BITS-1:0]    cmd_index,
	output logic                         rsp_valid,
	output logic                         rsp_granted,
	output logic                         rsp_flag,
	// Memory port pins
	output logic                         token_space_select_n,
	output logic                         array_select_n,
	output logic                         write_n,
	output logic                         output_enable_n,
	output logic [3:0]                   byte_lane_enable_n,
	output logic [ADDR_WIDTH-1:0]        address,
	output logic [DATA_WIDTH-1:0]        data_out,
	output logic                         data_oe_n,
	input  wire logic [DATA_WIDTH-1:0]   data_in
);
	import sem_host_pkg::*;

	typedef enum logic [2:0] {IDLE, ISSUE, WAIT, REPORT} seq_state_t;

	sem_strobe_if bus ();

	seq_state_t             state;
	seq_state_t             next_state;
	cmd_t                   op;
	cmd_t                   next_op;
	logic [FLAG_BITS-1:0]   index;
	logic [FLAG_BITS-1:0]   next_index;
	logic                   phase_read;
	logic                   next_phase_read;
	logic [7:0]             tries;
	logic [7:0]             next_tries;
	logic                   granted;
	logic                   next_granted;
	logic                   flag;
	logic                   next_flag;

	sem_pin_cycle u_pins
	(
		.clk_sys              (clk_sys),
		.reset_n              (reset_n),
		.clk_en               (clk_en),
		.req                  (bus.drv),
		.token_space_select_n (token_space_select_n),
		.array_select_n       (array_select_n),
		.write_n              (write_n),
		.output_enable_n      (output_enable_n),
		.byte_lane_enable_n   (byte_lane_enable_n),
		.address              (address),
		.data_out             (data_out),
		.data_oe_n            (data_oe_n),
		.data_in              (data_in)
	);

	// Write leg of each command; peek is a pure read
	function automatic logic leg_write(input cmd_t c, input logic rd);
		return (c != CMD_PEEK) && !rd;
	endfunction

	always_comb
	begin
		next_state      = state;
		next_op         = op;
		next_index      = index;
		next_phase_read = phase_read;
		next_tries      = tries;
		next_granted    = granted;
		next_flag       = flag;
		unique case (state)
			IDLE:
			begin
				// One command at a time; busy states refuse the next
				if (cmd_valid)
				begin
					next_op         = cmd_op;
					next_index      = (cmd_op == CMD_INIT) ? '0 : cmd_index;
					next_phase_read = (cmd_op == CMD_PEEK);
					next_tries      = 8'h0;
					next_state      = ISSUE;
				end
			end
			// Start is one cycle wide; the pin driver latches the access
			ISSUE:
				next_state = WAIT;
			// Each leg ends in a deselected gap, so every read re-latches
			WAIT:
			begin
				if (bus.done)
				begin
					next_state = ISSUE;
					unique case (op)
						CMD_ACQUIRE:
						begin
							if (!phase_read)
								next_phase_read = 1'b1; // see [RL14]
							else if (!bus.rbit)
							begin
								next_granted = 1'b1; // see [RL6]
								next_flag    = 1'b0;
								next_state   = REPORT;
							end
							else if (tries == 8'(RETRY_LIMIT - 1))
							begin
								// Withdraw so a stale request cannot hang the flag
								next_op         = CMD_RELEASE; // see [RL15]
								next_phase_read = 1'b0;
								next_granted    = 1'b0;
							end
							else
								next_tries = tries + 8'h1; // see [RL15]
						end
						CMD_RELEASE:
						begin
							next_flag  = 1'b1; // see [RL2]
							next_state = REPORT;
						end
						// Init ignores the index and sweeps all eight flags
						CMD_INIT:
						begin
							next_flag = 1'b1; // see [RL17]
							if (index == 3'(FLAG_COUNT - 1))
								next_state = REPORT;
							else
								next_index = index + 3'h1;
						end
						CMD_PEEK:
						begin
							next_flag    = bus.rbit; // see [RL11]
							next_granted = !bus.rbit;
							next_state   = REPORT;
						end
					endcase
				end
			end
			// Grant lasts only with the pulse; the flag stays for status
			REPORT:
			begin
				next_state   = IDLE;
				next_granted = 1'b0;
			end
			default:
				next_state = IDLE;
		endcase
	end

	// Clock enable low freezes the sequence and the pins with it
	always_ff @(posedge clk_sys)
	begin
		if (!reset_n)
		begin
			state      <= IDLE;
			op         <= CMD_INIT;
			index      <= '0;
			phase_read <= 1'b0;
			tries      <= 8'h0;
			granted    <= 1'b0;
			flag       <= 1'b1;
		end
		else if (clk_en)
		begin
			state      <= next_state;
			op         <= next_op;
			index      <= next_index;
			phase_read <= next_phase_read;
			tries      <= next_tries;
			granted    <= next_granted;
			flag       <= next_flag;
		end
	end

	// Handshake outputs decode the state register directly
	assign cmd_ready   = (state == IDLE);
	assign rsp_valid   = (state == REPORT);
	assign rsp_granted = granted;
	assign rsp_flag    = flag;

	assign bus.start = (state == ISSUE) && clk_en;
	assign bus.write = leg_write(op, phase_read); // see [RL2]
	assign bus.index = index;
	// Request is zero, release and init are one
	assign bus.wbit  = (op != CMD_ACQUIRE); // see [RL2]
endmodule

// *** verilog/sem_pin_cycle.sv ***
// Drives one token-space read or write on the memory port pins.
// Assumes the far device samples pins asynchronously; all pins leave flip-flops.
`timescale 1ns/1ps
module sem_pin_cycle
	import sem_host_pkg::*;
(
	// Clock and reset
	input  wire logic                    clk_sys,
	input  wire logic                    reset_n,
	input  wire logic                    clk_en,
	// Sequencer side
	sem_strobe_if.drv                    req,
	// Memory port pins
	output logic                         token_space_select_n,
	output logic                         array_select_n,
	output logic                         write_n,
	output logic                         output_enable_n,
	output logic [3:0]                   byte_lane_enable_n,
	output logic [ADDR_WIDTH-1:0]        address,
	output logic [DATA_WIDTH-1:0]        data_out,
	output logic                         data_oe_n,
	input  wire logic [DATA_WIDTH-1:0]   data_in
);
	import sem_host_pkg::*;

	typedef enum logic [1:0] {IDLE, STROBE, GAP} pin_state_t;

	pin_state_t              state;
	pin_state_t              next_state;
	logic [3:0]              timer;
	logic [3:0]              next_timer;
	logic                    sel;
	logic                    next_sel;
	logic                    wr;
	logic                    next_wr;
	logic                    rbit;
	logic                    next_rbit;
	logic [FLAG_BITS-1:0]    index;
	logic [FLAG_BITS-1:0]    next_index;
	logic                    wbit;
	logic                    next_wbit;

	always_comb
	begin
		next_state = state;
		next_timer = timer;
		next_sel   = sel;
		next_wr    = wr;
		next_rbit  = rbit;
		next_index = index;
		next_wbit  = wbit;
		unique case (state)
			IDLE:
			begin
				if (req.start)
				begin
					next_state = STROBE;
					next_timer = 4'(STROBE_CYCLES);
					next_sel   = 1'b1;
					next_wr    = req.write;
					next_index = req.index;
					next_wbit  = req.wbit;
				end
			end
			STROBE:
			begin
				if (timer == 4'h1)
				begin
					// Sample before deselect; flag is stable while strobes held
					if (!wr)
						next_rbit = data_in[0]; // see [RL11]
					next_state = GAP;
					next_timer = 4'(GAP_CYCLES);
					next_sel   = 1'b0; // see [RL15]
				end
				else
					next_timer = timer - 4'h1;
			end
			GAP:
			begin
				if (timer == 4'h1)
					next_state = IDLE;
				else
					next_timer = timer - 4'h1;
			end
			default:
				next_state = IDLE;
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		if (!reset_n)
		begin
			state <= IDLE;
			timer <= TIMER_RESET;
			sel   <= 1'b0;
			wr    <= 1'b0;
			rbit  <= 1'b1;
			index <= '0;
			wbit  <= 1'b1;
		end
		else if (clk_en)
		begin
			state <= next_state;
			timer <= next_timer;
			sel   <= next_sel;
			wr    <= next_wr;
			rbit  <= next_rbit;
			index <= next_index;
			wbit  <= next_wbit;
		end
	end

	assign req.done = (state == GAP) && (timer == 4'h1);
	assign req.rbit = rbit;

	assign token_space_select_n = !sel; // see [RL3]
	assign array_select_n       = 1'b1; // see [RL18]
	assign write_n              = !(sel && wr);
	assign output_enable_n      = !(sel && !wr);
	assign byte_lane_enable_n   = sel ? BYTE_LANES_ON : BYTE_LANES_OFF;
	// Upper address bits held low; the device ignores them anyway
	assign address              = {{(ADDR_WIDTH-FLAG_BITS){1'b0}}, index}; // see [RL4]
	assign data_out             = {{(DATA_WIDTH-1){1'b0}}, wbit}; // see [RL5]
	assign data_oe_n            = !(sel && wr);
endmodule
